// >>> src/ddp_defs.svh
// door drive option/parking logic: offsets, fields, resets, timing
// assumes a 125 MHz clock and millimetre position units
`ifndef DDP_DEFS_SVH
`define DDP_DEFS_SVH
`define DDP_OFF_CFG0      8'h00
`define DDP_OFF_CFG1      8'h04
`define DDP_OFF_PSO0      8'h08
`define DDP_OFF_PSO1      8'h0c
`define DDP_OFF_LEARN     8'h10
`define DDP_OFF_STAT      8'h14
`define DDP_RST_FF_OPT    2'h1
`define DDP_RST_AUX_OPT   2'h3
`define DDP_RST_DOS_OPT   1'h1
`define DDP_RST_PARK_MODE 1'h0
`define DDP_RST_POS_CTRL  1'h0
`define DDP_RST_EM_MIN    3'h1
`define DDP_RST_PCT       7'h32
`define DDP_RST_TOL       6'h19
`define DDP_RST_DELAY     10'h0f0
`define DDP_RST_SPACE     8'h14
`define DDP_RST_ERR       5'h0a
`define DDP_RST_LEARN     16'h0320
`define DDP_PIN_FFC       0
`define DDP_PIN_EMO       1
`define DDP_PIN_OPEN      2
`define DDP_PIN_CLOSE     3
`define DDP_PIN_REV       4
`define DDP_PIN_BUMP      5
`define DDP_PIN_ALARM     6
`define DDP_PIN_HOT       7
`define DDP_CLOSED_MM     16'h0002
`define DDP_CLK_PERIOD_NS 8
`define DDP_SEC_NS        1000000000
`define DDP_SEC_CYCLES    (`DDP_SEC_NS / `DDP_CLK_PERIOD_NS)
`define DDP_SEC_PER_MIN   9'h03c
`define DDP_EM_CLOSE_S    9'h00a
`endif

// >>> src/ddp_pkg.sv
// door drive option/parking logic: state types
// one-hot state codes are set here, not taken from ddp_defs.svh
package ddp_pkg;
    typedef enum logic [6:0] {
        P_NORMAL  = 7'b0000001,
        P_CLPARK  = 7'b0000010,
        P_DELAY   = 7'b0000100,
        P_SKOPEN  = 7'b0001000,
        P_PSO     = 7'b0010000,
        P_SKCLOSE = 7'b0100000,
        P_DROPPED = 7'b1000000
    } ddp_park_t;
    typedef enum logic [3:0] {
        E_IDLE  = 4'b0001,
        E_OPEN  = 4'b0010,
        E_HOLD  = 4'b0100,
        E_CLOSE = 4'b1000
    } ddp_em_t;
endpackage : ddp_pkg

// >>> src/ddp_sec_tick.sv
// one-cycle pulse once per second
// assumes SEC_CYCLES is the clock count of one second
`timescale 1ns/1ns
module ddp_sec_tick #(
    parameter int SEC_CYCLES = 125000000
) (
    input  wire logic CLK,
    input  wire logic RESET_N,
    output logic      TICK
);
    typedef struct packed {
        logic [31:0] cnt;
        logic        tick;
    } ddp_tick_t;
    ddp_tick_t r;
    ddp_tick_t n;
    always_comb begin
        n = r;
        n.tick = (r.cnt == 32'(SEC_CYCLES - 1));
        n.cnt = n.tick ? 32'h0 : r.cnt + 32'h1;
    end
    always_ff @(posedge CLK or negedge RESET_N) begin
        if (!RESET_N) begin
            r <= '0;
        end else begin
            r <= n;
        end
    end
    assign TICK = r.tick;
endmodule : ddp_sec_tick

// >>> src/ddp_top.sv
// door drive option handling and closed-door parking, AHB-Lite slave
// assumes position from same-clock motor logic; command pins asynchronous
//
// Added by the designer: the placing of the registers and the AHB-Lite interface to the registers.
`timescale 1ns/1ns
`include "ddp_defs.svh"

module ddp_top #(
    parameter int SEC_CYCLES = `DDP_SEC_CYCLES
) (
    input  wire logic        CLK,
    input  wire logic        RESET_N,
    input  wire logic        HSEL,
    input  wire logic [31:0] HADDR,
    input  wire logic [1:0]  HTRANS,
    input  wire logic        HWRITE,
    input  wire logic [2:0]  HSIZE,
    input  wire logic [31:0] HWDATA,
    input  wire logic        HREADY,
    output logic      [31:0] HRDATA,
    output logic             HREADYOUT,
    output logic             HRESP,
    input  wire logic        FIRE_FIGHTING_COMMAND,
    input  wire logic        EMERGENCY_OPEN_INPUT,
    input  wire logic        OPEN_COMMAND,
    input  wire logic        CLOSE_COMMAND,
    input  wire logic        REVERSE_SOURCE,
    input  wire logic        BUMPER_HIT,
    input  wire logic        ALARM,
    input  wire logic        MOTOR_OVERHEAT,
    input  wire logic [15:0] POSITION_MM,
    output logic             DOOR_OPEN_STATUS_OUTPUT,
    output logic             AUX_RELAY_OUTPUT,
    output logic             DOOR_CLOSED_OUTPUT,
    output logic             FORCE_LIMIT_EN,
    output logic             FORCE_MIN_SENS,
    output logic             REVERSE_EN,
    output logic             MOTOR_OPEN,
    output logic             MOTOR_CLOSE,
    output logic             MOTOR_REDUCED,
    output logic      [15:0] MOTOR_TARGET_MM,
    output logic             PARK_TORQUE,
    output logic             MOTOR_POWER_EN
);
    import ddp_pkg::*;

    typedef struct packed {
        logic [7:0]  sync1;
        logic [7:0]  sync2;
        logic        close_prev;
        logic        em_prev;
        logic [1:0]  ff_opt;
        logic [1:0]  aux_opt;
        logic        dos_opt;
        logic        park_mode;
        logic        pos_ctrl;
        logic [2:0]  em_min;
        logic [6:0]  pct;
        logic [5:0]  tol;
        logic [9:0]  delay_s;
        logic [7:0]  space;
        logic [4:0]  err;
        logic [15:0] learned;
        logic        wr_pend;
        logic [7:0]  wr_addr;
        logic [31:0] hrdata;
        logic        hready;
        ddp_park_t   park;
        ddp_em_t     em;
        logic [9:0]  park_sec;
        logic [8:0]  em_sec;
        logic        door_open_status_output;
        logic        aux;
        logic        door_closed_output;
        logic        fl_en;
        logic        fl_min;
        logic        rev_en;
        logic        m_open;
        logic        m_close;
        logic        m_red;
        logic [15:0] m_tgt;
        logic        park_torque;
        logic        power_en;
    } ddp_state_t;

    ddp_state_t  r;
    ddp_state_t  n;
    logic        tick;
    logic        ffc;
    logic        emo;
    logic        opn;
    logic        cls;
    logic        closed;
    logic        open_pos;
    logic        access;
    logic [15:0] open_thr;
    logic [15:0] err_lim;
    logic [8:0]  em_total;
    logic [23:0] pos_x100;
    logic [23:0] pct_lim;

    function automatic logic [15:0] clamp16(input logic [15:0] v,
                                            input logic [15:0] lo,
                                            input logic [15:0] hi);
        clamp16 = (v < lo) ? lo : ((v > hi) ? hi : v);
    endfunction : clamp16

    ddp_sec_tick #(
        .SEC_CYCLES (SEC_CYCLES)
    ) u_tick (
        .CLK     (CLK),
        .RESET_N (RESET_N),
        .TICK    (tick)
    );

    ////////////////////////////////////////////////////////////////////////////
    always_comb begin
        n = r;
        n.sync1 = {MOTOR_OVERHEAT, ALARM, BUMPER_HIT, REVERSE_SOURCE,
                   CLOSE_COMMAND, OPEN_COMMAND, EMERGENCY_OPEN_INPUT,
                   FIRE_FIGHTING_COMMAND};
        n.sync2 = r.sync1;
        ffc = r.sync2[`DDP_PIN_FFC];
        emo = r.sync2[`DDP_PIN_EMO];
        opn = r.sync2[`DDP_PIN_OPEN];
        cls = r.sync2[`DDP_PIN_CLOSE];
        n.close_prev = cls;
        n.em_prev = emo;
        closed = (POSITION_MM <= `DDP_CLOSED_MM);
        open_thr = (r.learned > 16'(r.tol)) ? r.learned - 16'(r.tol) : 16'h0;
        // bumper counts only while moving open or already open, so a stall
        // elsewhere is no open and the motor stop cannot make the status flicker
        open_pos = (POSITION_MM >= open_thr) ||
                   ((r.m_open || r.door_open_status_output) && r.sync2[`DDP_PIN_BUMP]);
        err_lim = 16'(r.space) + 16'(r.err);
        em_total = 9'(r.em_min) * `DDP_SEC_PER_MIN;
        pos_x100 = 24'(POSITION_MM) * 24'h000064;
        pct_lim = 24'(r.pct) * 24'(r.learned);

        // bus: write lands in the data phase, read data set up one phase early
        access = HSEL && HTRANS[1] && HREADY;
        n.wr_pend = access && HWRITE;
        n.wr_addr = HADDR[7:0];
        if (r.wr_pend) begin
            case (r.wr_addr)
                `DDP_OFF_CFG0: begin
                    n.ff_opt = HWDATA[1:0];
                    n.aux_opt = HWDATA[3:2];
                    n.dos_opt = HWDATA[4];
                    n.park_mode = HWDATA[5];
                    n.pos_ctrl = HWDATA[6];
                    n.em_min = 3'(clamp16(16'(HWDATA[10:8]), 16'h1, 16'h5));
                end
                `DDP_OFF_CFG1: begin
                    n.pct = 7'(clamp16(16'(HWDATA[6:0]), 16'h0, 16'h64));
                    n.tol = 6'(clamp16(16'(HWDATA[13:8]), 16'h5, 16'h28));
                end
                `DDP_OFF_PSO0: begin
                    n.delay_s = 10'(clamp16(16'(HWDATA[9:0]), 16'h5, 16'h3e7));
                    n.space = 8'(clamp16(16'(HWDATA[23:16]), 16'h5, 16'h96));
                end
                `DDP_OFF_PSO1: begin
                    n.err = 5'(clamp16(16'(HWDATA[4:0]), 16'h2, 16'h14));
                end
                `DDP_OFF_LEARN: begin
                    n.learned = HWDATA[15:0];
                end
                default: begin
                end
            endcase
        end
        if (access && !HWRITE) begin
            case (HADDR[7:0])
                `DDP_OFF_CFG0: n.hrdata = {21'h0, r.em_min, 1'b0, r.pos_ctrl,
                                           r.park_mode, r.dos_opt, r.aux_opt, r.ff_opt};
                `DDP_OFF_CFG1: n.hrdata = {18'h0, r.tol, 1'b0, r.pct};
                `DDP_OFF_PSO0: n.hrdata = {8'h0, r.space, 6'h0, r.delay_s};
                `DDP_OFF_PSO1: n.hrdata = {27'h0, r.err};
                `DDP_OFF_LEARN: n.hrdata = {16'h0, r.learned};
                `DDP_OFF_STAT: n.hrdata = {r.em_sec, r.em, r.park, r.power_en,
                                           r.park_torque, r.m_close, r.m_open,
                                           r.aux, r.door_closed_output, r.door_open_status_output};
                default: n.hrdata = 32'h0;
            endcase
        end
        n.hready = 1'b1;

        // emergency opening cycle, timed from its start to closed again
        if (r.em != E_IDLE) begin
            n.em_sec = (r.em_sec >= em_total) ? em_total
                                              : r.em_sec + 9'(tick);
        end
        case (r.em)
            E_IDLE: if (emo && !r.em_prev) begin
                n.em = E_OPEN;
                n.em_sec = 9'h0;
            end
            E_OPEN: if (open_pos) begin
                n.em = E_HOLD;
            end
            // close allowance reserved so the cycle ends near the set total
            E_HOLD: if (r.em_sec + `DDP_EM_CLOSE_S >= em_total) begin
                n.em = E_CLOSE;
            end
            E_CLOSE: if (closed) begin
                n.em = E_IDLE;
            end
            default: n.em = E_IDLE;
        endcase

        // closed parking sequence
        if (r.park == P_DELAY) begin
            n.park_sec = (r.park_sec == 10'h3ff) ? r.park_sec : r.park_sec + 10'(tick);
        end
        case (r.park)
            P_NORMAL: if (closed && cls && !opn) begin
                n.park = P_CLPARK;
            end
            P_CLPARK: begin
                if (opn || !closed) begin
                    n.park = P_NORMAL;
                end else if (r.park_mode && r.close_prev && !cls) begin
                    n.park = P_DELAY;
                    n.park_sec = 10'h0;
                end
            end
            P_DELAY: begin
                if (opn || !closed) begin
                    n.park = P_NORMAL;
                end else if (cls) begin
                    n.park = P_CLPARK;
                end else if (r.park_sec >= r.delay_s) begin
                    n.park = P_SKOPEN;
                end
            end
            P_SKOPEN: begin
                if (opn) begin
                    n.park = P_NORMAL;
                end else if (cls) begin
                    n.park = P_SKCLOSE;
                end else if (POSITION_MM >= 16'(r.space)) begin
                    n.park = P_PSO;
                end
            end
            P_PSO: begin
                if (opn) begin
                    n.park = P_NORMAL;
                end else if (cls) begin
                    n.park = P_SKCLOSE;
                end else if (POSITION_MM > err_lim) begin
                    n.park = P_DROPPED;
                end
            end
            P_SKCLOSE: begin
                if (opn) begin
                    n.park = P_NORMAL;
                end else if (closed) begin
                    n.park = P_CLPARK;
                end
            end
            P_DROPPED: if (opn || cls) begin
                n.park = P_NORMAL;
            end
            default: n.park = P_NORMAL;
        endcase

        // motor requests: emergency, then open, then parking moves, then close
        n.m_open = 1'b0;
        n.m_close = 1'b0;
        n.m_red = 1'b0;
        n.m_tgt = 16'h0;
        if (r.em == E_OPEN || r.em == E_HOLD) begin
            n.m_open = (r.em == E_OPEN);
            n.m_tgt = r.learned;
        end else if (r.em == E_CLOSE) begin
            n.m_close = 1'b1;
        end else if (opn) begin
            n.m_open = !open_pos;
            n.m_tgt = r.learned;
        end else if (r.park == P_SKOPEN) begin
            n.m_open = 1'b1;
            n.m_red = 1'b1;
            n.m_tgt = 16'(r.space);
        end else if (r.park == P_SKCLOSE) begin
            n.m_close = 1'b1;
            n.m_red = 1'b1;
        end else if (cls && !closed) begin
            n.m_close = 1'b1;
        end
        n.park_torque = (r.park == P_CLPARK) || (r.park == P_DELAY);
        if (r.park == P_PSO) begin
            n.power_en = r.pos_ctrl && (POSITION_MM > 16'(r.space));
        end else begin
            n.power_en = 1'b1;
        end

        // status and safety outputs
        n.rev_en = r.sync2[`DDP_PIN_REV] && !ffc;
        n.fl_en = !(ffc && r.ff_opt == 2'h0);
        n.fl_min = ffc && (r.ff_opt == 2'h1);
        n.door_open_status_output = open_pos && (r.dos_opt || opn);
        case (r.aux_opt)
            2'h0: n.aux = 1'b0;
            2'h1: n.aux = r.m_open;
            2'h2: n.aux = (pos_x100 > pct_lim);
            default: n.aux = r.sync2[`DDP_PIN_ALARM] || r.sync2[`DDP_PIN_HOT];
        endcase
        case (r.park)
            P_DELAY, P_SKOPEN, P_PSO, P_SKCLOSE: n.door_closed_output = 1'b1;
            P_DROPPED: n.door_closed_output = 1'b0;
            default: n.door_closed_output = closed;
        endcase
    end

    ////////////////////////////////////////////////////////////////////////////
    always_ff @(posedge CLK or negedge RESET_N) begin
        if (!RESET_N) begin
            r <= '0;
            r.ff_opt <= `DDP_RST_FF_OPT;
            r.aux_opt <= `DDP_RST_AUX_OPT;
            r.dos_opt <= `DDP_RST_DOS_OPT;
            r.park_mode <= `DDP_RST_PARK_MODE;
            r.pos_ctrl <= `DDP_RST_POS_CTRL;
            r.em_min <= `DDP_RST_EM_MIN;
            r.pct <= `DDP_RST_PCT;
            r.tol <= `DDP_RST_TOL;
            r.delay_s <= `DDP_RST_DELAY;
            r.space <= `DDP_RST_SPACE;
            r.err <= `DDP_RST_ERR;
            r.learned <= `DDP_RST_LEARN;
            r.hready <= 1'b1;
            r.park <= P_NORMAL;
            r.em <= E_IDLE;
            r.fl_en <= 1'b1;
            r.power_en <= 1'b1;
        end else begin
            r <= n;
        end
    end

    assign HRDATA = r.hrdata;
    assign HREADYOUT = r.hready;
    assign HRESP = 1'b0;
    assign DOOR_OPEN_STATUS_OUTPUT = r.door_open_status_output;
    assign AUX_RELAY_OUTPUT = r.aux;
    assign DOOR_CLOSED_OUTPUT = r.door_closed_output;
    assign FORCE_LIMIT_EN = r.fl_en;
    assign FORCE_MIN_SENS = r.fl_min;
    assign REVERSE_EN = r.rev_en;
    assign MOTOR_OPEN = r.m_open;
    assign MOTOR_CLOSE = r.m_close;
    assign MOTOR_REDUCED = r.m_red;
    assign MOTOR_TARGET_MM = r.m_tgt;
    assign PARK_TORQUE = r.park_torque;
    assign MOTOR_POWER_EN = r.power_en;

    ////////////////////////////////////////////////////////////////////////////
    default clocking cb @(posedge CLK);
    endclocking
    default disable iff (!RESET_N);

    ffc_no_rev_a: assert property (r.sync2[`DDP_PIN_FFC] |=> !REVERSE_EN)
        else $error("reversing enabled under fire-fighting command");
    ffc_fl_off_a: assert property ((r.sync2[`DDP_PIN_FFC] && r.ff_opt == 2'h0)
        |=> !FORCE_LIMIT_EN)
        else $error("force limiter on with option 00");
    ffc_fl_min_a: assert property ((r.sync2[`DDP_PIN_FFC] && r.ff_opt == 2'h1)
        |=> FORCE_LIMIT_EN && FORCE_MIN_SENS)
        else $error("force limiter not at minimum sensitivity");
    em_start_a: assert property ((r.em == E_IDLE && emo && !r.em_prev)
        |=> r.em == E_OPEN ##1 MOTOR_OPEN || DOOR_OPEN_STATUS_OUTPUT)
        else $error("emergency opening did not start");
    em_bound_a: assert property ($stable(r.em_min) && r.em != E_IDLE
        |=> r.em_sec <= 9'(r.em_min) * `DDP_SEC_PER_MIN)
        else $error("emergency cycle exceeded its total");
    aux_off_a: assert property (r.aux_opt == 2'h0 |=> !AUX_RELAY_OUTPUT)
        else $error("aux relay active while disabled");
    dos_cmd_a: assert property ((r.dos_opt == 1'b0 && !opn)
        |=> !DOOR_OPEN_STATUS_OUTPUT)
        else $error("open status without command in option 00");
    tol_range_a: assert property (r.tol >= 6'h05 && r.tol <= 6'h28)
        else $error("open tolerance out of range");
    delay_done_a: assert property ($rose(r.park == P_SKOPEN)
        |-> $past(r.park_sec) >= $past(r.delay_s))
        else $error("skate opened before entry delay");
    pso_drop_a: assert property ((r.park == P_PSO && !opn && !cls
        && POSITION_MM > err_lim) |=> r.park == P_DROPPED ##1 !DOOR_CLOSED_OUTPUT)
        else $error("position error did not drop closed output");
    delay_back_a: assert property ((r.park == P_DELAY && cls && !opn && closed)
        |=> r.park == P_CLPARK)
        else $error("close in entry delay did not return to parking");
    open_wins_a: assert property ((r.park == P_PSO && opn && r.em == E_IDLE)
        |=> r.park == P_NORMAL)
        else $error("open command did not leave open-skate parking");

    pso_reach_c: cover property (r.park == P_SKOPEN ##1 r.park == P_PSO);
    pso_drop_c: cover property (r.park == P_DROPPED);
    skate_close_c: cover property (r.park == P_SKCLOSE ##1 r.park == P_CLPARK);
    em_hold_c: cover property (r.em == E_HOLD ##1 r.em == E_CLOSE);
endmodule : ddp_top

// >>> testbench/ddp_lift_ctrl.sv
// lift controller model: turns bench requests into door commands
// assumes requests change just after a rising edge of CLK
`timescale 1ns/1ns
module ddp_lift_ctrl (
    input  wire logic CLK,
    input  wire logic RESET_N,
    input  wire logic WANT_OPEN,
    input  wire logic WANT_PARK,
    output logic      OPEN_CMD,
    output logic      CLOSE_CMD
);
    ////////////////////////////////////////////////////////////////////////////////
    // close command is dropped while open or park is wanted and held otherwise,
    // so it is back long before any travel; no alarm logic at all
    always_ff @(posedge CLK or negedge RESET_N) begin
        if (!RESET_N) begin
            OPEN_CMD  <= 1'b0;
            CLOSE_CMD <= 1'b0;
        end else begin
            OPEN_CMD  <= WANT_OPEN;
            CLOSE_CMD <= !WANT_OPEN && !WANT_PARK;
        end
    end
endmodule : ddp_lift_ctrl

// >>> testbench/door_drive_option_and_parking_logic_test.sv
// self-checking bench for the door option and parking block
// assumes ddp_top, the lift controller model and a 125 MHz clock
`timescale 1ns/1ns
`include "ddp_defs.svh"
module door_drive_option_and_parking_logic_test;
    localparam int SEC = 20; // short second keeps the run small
    logic        clk = 0, reset_n = 0, hsel = 0, hwrite = 0, hready, want_open = 0;
    logic        ffc = 0, emo = 0, rev = 0, alm = 0, hot = 0, want_park = 0, a, bump = 0;
    logic        open_cmd, close_cmd, door_open_status_output, aux, door_closed_output, fl_en, fl_min, rev_en, m_open, m_red, pwr;
    logic        m_close, pt, hresp;
    logic [1:0]  htrans = 0;
    logic [31:0] haddr = 0, hwdata = 0, hrdata, rd;
    logic [15:0] pos = 0, tgt;
    logic [7:0]  offs [6] = '{8'h00, 8'h04, 8'h08, 8'h0c, 8'h10, 8'h18};
    logic [31:0] dflt [6] = '{32'h11d, 32'h1932, 32'h1400f0, 32'ha, 32'h320, 32'h0};
    integer      err_total = 0, total_checks = 0, seed = 32'hc799d074, i, p;

    always #4 clk = ~clk;

    ddp_lift_ctrl LIFT_MAIN_CONTROLLER (.CLK(clk), .RESET_N(reset_n), .WANT_OPEN(want_open),
        .WANT_PARK(want_park), .OPEN_CMD(open_cmd), .CLOSE_CMD(close_cmd));

    ddp_top #(.SEC_CYCLES(SEC)) DUT (.CLK(clk), .RESET_N(reset_n), .HSEL(hsel),
        .HADDR(haddr), .HTRANS(htrans), .HWRITE(hwrite), .HSIZE(3'h2), .HWDATA(hwdata),
        .HREADY(hready), .HRDATA(hrdata), .HREADYOUT(hready), .HRESP(hresp),
        .FIRE_FIGHTING_COMMAND(ffc), .EMERGENCY_OPEN_INPUT(emo), .OPEN_COMMAND(open_cmd),
        .CLOSE_COMMAND(close_cmd), .REVERSE_SOURCE(rev), .BUMPER_HIT(bump), .ALARM(alm),
        .MOTOR_OVERHEAT(hot), .POSITION_MM(pos), .DOOR_OPEN_STATUS_OUTPUT(door_open_status_output),
        .AUX_RELAY_OUTPUT(aux), .DOOR_CLOSED_OUTPUT(door_closed_output), .FORCE_LIMIT_EN(fl_en),
        .FORCE_MIN_SENS(fl_min), .REVERSE_EN(rev_en), .MOTOR_OPEN(m_open),
        .MOTOR_CLOSE(m_close), .MOTOR_REDUCED(m_red), .MOTOR_TARGET_MM(tgt),
        .PARK_TORQUE(pt), .MOTOR_POWER_EN(pwr));

    ////////////////////////////////////////////////////////////////////////////////
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        total_checks++;
        if (got !== exp) begin
            err_total++;
            $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk

    // one single word transfer; read data lands in rd
    task automatic bus(input logic wr, input logic [7:0] a8, input logic [31:0] d);
        @(posedge clk);
        hsel   <= 1'b1;
        htrans <= 2'h2;
        hwrite <= wr;
        haddr  <= {24'h0, a8};
        do @(posedge clk); while (hready !== 1'b1);
        htrans <= 2'h0;
        hwdata <= d;
        do @(posedge clk); while (hready !== 1'b1);
        rd = hrdata;
        hsel <= 1'b0;
    endtask : bus

    task automatic cyc(input int n);
        repeat (n) @(posedge clk);
    endtask : cyc

    task automatic close_out;
        $display("checks=%0d errors=%0d", total_checks, err_total);
        if (err_total == 0 && total_checks > 0) $display("RESULT: PASS");
        else $display("RESULT: FAIL");
        $finish;
    endtask : close_out

    function automatic logic [31:0] cfg0(int ff, int ax, int ds, int pk);
        return 32'h100 | 32'(pk << 5) | 32'(ds << 4) | 32'(ax << 2) | 32'(ff);
    endfunction : cfg0

    function automatic logic exp_aux(int o, int q, logic e);
        case (o)
            0: return 1'b0;
            1: return 1'b1; // door still short of open, so opening
            2: return q * 100 > `DDP_RST_PCT * `DDP_RST_LEARN;
            default: return e;
        endcase
    endfunction : exp_aux

    ////////////////////////////////////////////////////////////////////////////////
    initial begin
        #(8 * 20000);
        err_total++;
        close_out();
    end

    initial begin
        repeat (2) @(posedge clk);
        reset_n <= 1'b1;
        bus(1'b1, 8'h18, 32'hffffffff); // unmapped place must stay empty
        for (i = 0; i < 6; i++) begin
            bus(1'b0, offs[i], 32'h0);
            chk(rd, dflt[i]);
        end
        chk(hresp, 0);
        rev <= 1'b1;
        ffc <= 1'b1;
        for (i = 0; i < 2; i++) begin
            bus(1'b1, `DDP_OFF_CFG0, cfg0(i, 3, 1, 0));
            cyc(5);
            chk(rev_en, 0);
            chk(fl_en, i != 0);
            chk(fl_min, i == 1);
        end
        ffc <= 1'b0;
        cyc(5);
        chk(rev_en, 1);
        want_open <= 1'b1;
        for (i = 0; i < 12; i++) begin
            p = {$random(seed)} % 700;
            a = 1'($random(seed));
            pos <= 16'(p);
            alm <= a;
            hot <= !a && 1'($random(seed));
            bus(1'b1, `DDP_OFF_CFG0, cfg0(1, i % 4, 1, 0));
            cyc(5);
            chk(aux, exp_aux(i % 4, p, alm | hot));
        end
        want_park <= 1'b1;
        for (i = 0; i < 4; i++) begin
            want_open <= i == 3;
            pos <= (i == 1) ? 16'd774 : 16'd775;
            bus(1'b1, `DDP_OFF_CFG0, cfg0(1, 3, i < 2, 0));
            cyc(5);
            chk(door_open_status_output, i != 1 && i != 2);
        end
        want_open <= 1'b0;
        pos <= 16'd760;
        bus(1'b1, `DDP_OFF_CFG1, 32'h2832);
        bus(1'b1, `DDP_OFF_CFG0, cfg0(1, 3, 1, 0));
        cyc(5);
        chk(door_open_status_output, 1);
        pos <= 16'd500;
        bump <= 1'b1;
        want_open <= 1'b1;
        cyc(8);
        chk(door_open_status_output, 1);
        cyc(3);
        chk(door_open_status_output, 1);
        bump <= 1'b0;
        want_open <= 1'b0;
        cyc(8);
        chk(door_open_status_output, 0);
        pos <= 16'd0;
        want_park <= 1'b0;
        bus(1'b1, `DDP_OFF_PSO0, 32'h140005);
        bus(1'b1, `DDP_OFF_CFG0, cfg0(1, 3, 1, 1));
        cyc(8);
        chk(door_closed_output, 1);
        chk(pt, 1);
        want_park <= 1'b1;
        cyc(SEC);
        want_park <= 1'b0;
        cyc(6 * SEC);
        chk(m_open, 0);
        chk(door_closed_output, 1);
        want_park <= 1'b1;
        cyc(4 * SEC - 8);
        chk(m_open, 0);
        i = 0;
        while (m_open !== 1'b1 && i < 3 * SEC) begin
            @(posedge clk);
            i++;
        end
        cyc(1);
        chk(m_open, 1);
        chk(m_red, 1);
        chk(tgt, 20);
        pos <= 16'd20;
        cyc(5);
        chk(m_open, 0);
        chk(door_closed_output, 1);
        chk(pwr, 0);
        pos <= 16'd31;
        cyc(5);
        chk(door_closed_output, 0);
        want_park <= 1'b0;
        cyc(8);
        chk(m_close, 1);
        pos <= 16'd0;
        cyc(8);
        emo <= 1'b1;
        cyc(8);
        chk(m_open, 1);
        close_out();
    end
endmodule : door_drive_option_and_parking_logic_test
